//--- hdl/iosm_line.sv
`timescale 1ns/1ps
// one destination line: source select, off handling, inverter, force high
// assumes source vector already synchronised to clk_i
module iosm_line
   import iosm_pkg::*;
#(
   parameter int NSRC = NUM_SRC
) (
   // source vector and settings
   input wire logic [NSRC-1:0] src_i,
   input wire iosm_route_t route_i,
   // resulting line level
   output logic line_o
);
   logic routed;

   // select, then invert; force high precedes inverter so inverse gives low
   always_comb begin
      routed = 1'b0;
      if (int'(route_i.sel) < NSRC) begin
         routed = src_i[route_i.sel];
      end
      if (route_i.force_hi) begin
         routed = 1'b1;
      end
      line_o = routed ^ route_i.invert;
   end
endmodule

//--- hdl/iosm_matrix.sv
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// i/o switch matrix with per-entry pwm period and duty table, wishbone slave
// assumes external pins arrive asynchronously; internal modules share clk_i
// How it works
// - 25 sources, 18 destinations; each destination takes one chosen source.
// - sources 0 to 3 carry the four external trigger inputs.
// - sources 6, 7, 20, 21 carry flash generator outputs 0 to 3.
// - sources 8, 9, 13, 14 pwm a-d; 12 pulse a, 18 pulse b, 15 running.
// - source 16 debounce, 17 prescaler, 19 logic combiner result.
// - destinations 0-3 drive open-drain outputs; 4 drives serial tx unless debug.
// - destination 6 is camera trigger, 7 the sequencer hardware start.
// - destination 8 debounce, 9 prescaler, 10 and 11 logic combiner inputs.
// - destinations 13 to 16 start flash generators 0 to 3.
// - inverter option delivers the complement of the routed signal.
// - force-high drives the line high; with inverter it is held low.
// - pwm period equals stored count times the 15 ns tick.
// - each entry holds four duty percentages setting high time per period.
module iosm_matrix
   import iosm_pkg::*;
#(
   parameter int ENTRIES = SEQ_ENTRIES,
   parameter int PW = PERIOD_W
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // asynchronous pins
   input wire logic [3:0] ext_trig_i,
   input wire logic ser_rx_i,
   input wire logic ser2_rx_i,
   input wire logic debug_i,
   // internal sources on clk_i
   input wire logic [3:0] flash_out_i,
   input wire logic pulse_a_i,
   input wire logic pulse_b_i,
   input wire logic seq_running_i,
   input wire logic seq_active_entry_i,
   input wire logic [3:0] seq_entry_index_i,
   input wire logic debounce_out_i,
   input wire logic prescale_out_i,
   input wire logic logic_out_i,
   input wire logic expose_active_i,
   input wire logic readout_active_i,
   input wire logic trig_feedback_i,
   input wire logic port1_serial_tx_i,
   input wire logic port2_serial_tx_i,
   // open-drain outputs (oe high pulls low)
   output logic [3:0] od_out_o,
   output logic [3:0] od_oe_o,
   // routed destinations
   output logic ser_tx_o,
   output logic ser_tx_oe_o,
   output logic port1_serial_rx_o,
   output logic cam_trig_o,
   output logic seq_hw_start_o,
   output logic debounce_in_o,
   output logic prescale_in_o,
   output logic logic_a_o,
   output logic logic_b_o,
   output logic ser2_tx_o,
   output logic [3:0] flash_gen_hw_start_o,
   output logic port2_serial_rx_o,
   // pwm channels to the sequencer side
   output logic [PWM_CH-1:0] seq_pwm_chan_o
);
   // two-stage synchronisers for pin inputs
   // costs two cycles on pins; internal sources skip it to keep their latency
   logic [6:0] pin_meta_ff, pin_sync_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta_ff <= '0;
         pin_sync_ff <= '0;
      end else if (ce_i) begin
         pin_meta_ff <= {debug_i, ser2_rx_i, ser_rx_i, ext_trig_i};
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // source vector assembly
   logic [NUM_SRC-1:0] src;
   logic [PWM_CH-1:0] pwm;
   always_comb begin
      src = '0;
      src[SRC_TRIG0 +: 4] = pin_sync_ff[3:0];
      src[SRC_RX1] = pin_sync_ff[4];
      src[SRC_TX1] = port1_serial_tx_i;
      src[SRC_FLASH0] = flash_out_i[0];
      src[SRC_FLASH1] = flash_out_i[1];
      src[SRC_FLASH2] = flash_out_i[2];
      src[SRC_FLASH3] = flash_out_i[3];
      src[SRC_PWM_A] = pwm[0];
      src[SRC_PWM_B] = pwm[1];
      src[SRC_PWM_C] = pwm[2];
      src[SRC_PWM_D] = pwm[3];
      src[SRC_PULSE_A] = pulse_a_i;
      src[SRC_PULSE_B] = pulse_b_i;
      src[SRC_SEQ_RUN] = seq_running_i;
      src[SRC_DEBOUNCE] = debounce_out_i;
      src[SRC_PRESCALE] = prescale_out_i;
      src[SRC_LOGIC] = logic_out_i;
      src[SRC_EXPOSE] = expose_active_i;
      src[SRC_READOUT] = readout_active_i;
      src[SRC_RX2] = pin_sync_ff[5];
      src[SRC_TRIG_FB] = trig_feedback_i;
      src[SRC_TX2] = port2_serial_tx_i;
   end

   // route settings, one per destination
   iosm_route_t route_ff [NUM_DST];
   iosm_route_t nxt_route [NUM_DST];
   logic [NUM_DST-1:0] dst_comb;
   logic [NUM_DST-1:0] dst_ff;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_DST; gi++) begin : g_line
         iosm_line #(.NSRC(NUM_SRC)) u_line (
            .src_i(src),
            .route_i(route_ff[gi]),
            .line_o(dst_comb[gi])
         );
      end
   endgenerate

   // pwm table storage, one entry per sequencer step
   logic [PW-1:0] period_mem [ENTRIES];
   logic [PWM_CH*DUTY_W-1:0] duty_mem [ENTRIES];
   logic [3:0] entry_ff, nxt_entry;
   logic [3:0] run_entry;

   // live entry: sequencer picks while active, else software's index
   assign run_entry = seq_active_entry_i ? seq_entry_index_i : entry_ff;

   generate
      for (gi = 0; gi < PWM_CH; gi++) begin : g_pwm
         iosm_pwm #(.PW(PW)) u_pwm (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .run_i(seq_running_i),
            .period_i(period_mem[run_entry]),
            .duty_i(duty_mem[run_entry][gi*DUTY_W +: DUTY_W]),
            .pwm_o(pwm[gi])
         );
      end
   endgenerate
   assign seq_pwm_chan_o = pwm;

   // wishbone decode helpers
   function automatic logic is_route(input logic [ADDR_W-1:0] a);
      return (a < ADDR_ENTRY) && (a[1:0] == 2'b00);
   endfunction
   function automatic logic [31:0] lane_mask(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // route word layout: select low, invert and force at their own bits
   function automatic logic [31:0] route_word(input iosm_route_t r);
      logic [31:0] w;
      w = '0;
      w[SEL_W-1:0] = r.sel;
      w[RT_INV_BIT] = r.invert;
      w[RT_FORCE_BIT] = r.force_hi;
      return w;
   endfunction
   function automatic iosm_route_t word_route(input logic [31:0] w);
      iosm_route_t r;
      r.sel = w[SEL_W-1:0];
      r.invert = w[RT_INV_BIT];
      r.force_hi = w[RT_FORCE_BIT];
      return r;
   endfunction

   logic ack_ff, nxt_ack;
   logic [31:0] rdat_ff, nxt_rdat;
   logic req, wr;
   logic [31:0] wmask;
   logic [4:0] widx;

   assign req = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wr = req && wb_we_i;
   assign wmask = lane_mask(wb_sel_i);
   assign widx = wb_adr_i[6:2];

   // next state for registers and bus answer
   always_comb begin
      nxt_ack = req;
      nxt_entry = entry_ff;
      nxt_rdat = '0;
      for (int i = 0; i < NUM_DST; i++) begin
         nxt_route[i] = route_ff[i];
      end
      // bits outside select, invert and force are dropped on write
      if (wr && is_route(wb_adr_i)) begin
         nxt_route[widx] = word_route((route_word(route_ff[widx]) & ~wmask)
            | (wb_dat_i & wmask));
      end else if (wr && wb_adr_i == ADDR_ENTRY && wb_sel_i[0]) begin
         nxt_entry = wb_dat_i[3:0];
      end
      if (req && !wb_we_i) begin
         if (is_route(wb_adr_i)) begin
            nxt_rdat = route_word(route_ff[widx]);
         end else if (wb_adr_i == ADDR_ENTRY) begin
            nxt_rdat = 32'(entry_ff);
         end else if (wb_adr_i == ADDR_PERIOD) begin
            nxt_rdat = 32'(period_mem[entry_ff]);
         end else if (wb_adr_i == ADDR_DUTY) begin
            for (int c = 0; c < PWM_CH; c++) begin
               nxt_rdat[c*DUTY_LANE_W +: DUTY_W] = duty_mem[entry_ff][c*DUTY_W +: DUTY_W];
            end
         end else if (wb_adr_i == ADDR_STATUS) begin
            nxt_rdat = {23'h0, run_entry, pwm, seq_running_i};
         end else if (wb_adr_i == ADDR_DEST_VAL) begin
            nxt_rdat = 32'(dst_ff);
         end
      end
   end

   // registers, bus answer and registered destination lines
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_DST; i++) begin
            route_ff[i] <= ROUTE_RST;
         end
         entry_ff <= '0;
         ack_ff <= 1'b0;
         rdat_ff <= '0;
         dst_ff <= '0;
      end else if (ce_i) begin
         for (int i = 0; i < NUM_DST; i++) begin
            route_ff[i] <= nxt_route[i];
         end
         entry_ff <= nxt_entry;
         ack_ff <= nxt_ack;
         rdat_ff <= nxt_rdat;
         dst_ff <= dst_comb;
      end
   end

   // table memory: written per lane, no reset so it maps to ram
   always_ff @(posedge clk_i) begin
      if (ce_i && wr && wb_adr_i == ADDR_PERIOD) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
               period_mem[entry_ff][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
         end
      end
      if (ce_i && wr && wb_adr_i == ADDR_DUTY) begin
         for (int c = 0; c < PWM_CH; c++) begin
            if (wb_sel_i[c]) begin
               duty_mem[entry_ff][c*DUTY_W +: DUTY_W] <= wb_dat_i[c*DUTY_LANE_W +: DUTY_W];
            end
         end
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;

   // destination fan-out from registered lines
   // pad level stays low; the enable alone pulls the open-drain line down
   always_comb begin
      od_out_o = '0;
      od_oe_o = ~dst_ff[DST_OUT0 +: 4];
      ser_tx_o = dst_ff[DST_SER_TX];
      ser_tx_oe_o = !pin_sync_ff[6];
      port1_serial_rx_o = dst_ff[DST_PORT1_RX];
      cam_trig_o = dst_ff[DST_CAM_TRIG];
      seq_hw_start_o = dst_ff[DST_SEQ_START];
      debounce_in_o = dst_ff[DST_DEBOUNCE];
      prescale_in_o = dst_ff[DST_PRESCALE];
      logic_a_o = dst_ff[DST_LOGIC_A];
      logic_b_o = dst_ff[DST_LOGIC_B];
      ser2_tx_o = dst_ff[DST_SER2_TX];
      flash_gen_hw_start_o = dst_ff[DST_FLASH0 +: 4];
      port2_serial_rx_o = dst_ff[DST_PORT2_RX];
   end

   // checks on routing and bus answer
   sequence bus_req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_req_s |=> wb_ack_o) else $error("no ack one cycle after request");
   ack_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack held two cycles");
   off_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && route_ff[DST_CAM_TRIG].sel == SEL_OFF && !route_ff[DST_CAM_TRIG].invert
      && !route_ff[DST_CAM_TRIG].force_hi |=> !cam_trig_o)
      else $error("off line not low");
   force_hi_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && route_ff[DST_OUT0].force_hi |=> od_oe_o[0] == $past(route_ff[DST_OUT0].invert))
      else $error("force high not applied");
   trig_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && route_ff[DST_CAM_TRIG].sel == SEL_W'(SRC_TRIG0)
      && !route_ff[DST_CAM_TRIG].force_hi
      |=> cam_trig_o == ($past(pin_sync_ff[0]) ^ $past(route_ff[DST_CAM_TRIG].invert)))
      else $error("trigger input routing wrong");
   flash_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && route_ff[DST_FLASH0].sel == SEL_W'(SRC_FLASH2)
      && !route_ff[DST_FLASH0].force_hi
      && !route_ff[DST_FLASH0].invert |=> flash_gen_hw_start_o[0] == $past(flash_out_i[2]))
      else $error("flash source 20 routing wrong");
   debug_tx_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pin_sync_ff[6] |-> !ser_tx_oe_o) else $error("tx driven in debug");

   // a route write lands in line 0's select at the taking edge
   sequence route0_wr_s;
      ce_i && wr && wb_adr_i == ADDR_ROUTE_BASE && wb_sel_i[0];
   endsequence
   route_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      route0_wr_s |=> route_ff[DST_OUT0].sel == $past(wb_dat_i[SEL_W-1:0]))
      else $error("route select not written");
   // line status read returns the lines as they stood when taken
   sequence dest_rd_s;
      ce_i && req && !wb_we_i && wb_adr_i == ADDR_DEST_VAL;
   endsequence
   dest_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      dest_rd_s |=> wb_dat_o == 32'($past(dst_ff)))
      else $error("line status read wrong");
   // pwm idles low whenever the sequencer is stopped
   pwm_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !seq_running_i |=> seq_pwm_chan_o == '0)
      else $error("pwm active while stopped");
   // debug pin reaches the tx enable after both synchroniser flops
   sequence two_en_s;
      ce_i ##1 ce_i;
   endsequence
   debug_lat_a: assert property (@(posedge clk_i) disable iff (rst_i)
      two_en_s |=> ser_tx_oe_o == !$past(debug_i, 2))
      else $error("debug pin latency wrong");
endmodule

//--- hdl/iosm_pwm.sv
`timescale 1ns/1ps
// one pwm channel: period in ticks, high time as percentage of period
// assumes clk_i is the system tick clock
module iosm_pwm
   import iosm_pkg::*;
#(
   parameter int PW = PERIOD_W
) (
   // clock and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic run_i,
   // settings
   input wire logic [PW-1:0] period_i,
   input wire logic [DUTY_W-1:0] duty_i,
   // waveform
   output logic pwm_o
);
   logic [PW-1:0] cnt_ff, nxt_cnt;
   logic pwm_ff, nxt_pwm;
   logic [PW+DUTY_W-1:0] prod;
   logic [PW-1:0] high_ticks;

   // high time = period * duty / 100, rounded down
   always_comb begin
      prod = PW'(period_i) * DUTY_W'(duty_i);
      high_ticks = PW'(prod / (PW+DUTY_W)'(DUTY_FULL));
      nxt_cnt = cnt_ff;
      nxt_pwm = 1'b0;
      if (run_i && period_i != '0) begin
         nxt_cnt = (cnt_ff >= period_i - PW'(1)) ? '0 : cnt_ff + PW'(1);
         nxt_pwm = (nxt_cnt < high_ticks);
      end else begin
         nxt_cnt = '0;
      end
   end

   // registered for a glitch-free output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_ff <= '0;
         pwm_ff <= 1'b0;
      end else if (ce_i) begin
         cnt_ff <= nxt_cnt;
         pwm_ff <= nxt_pwm;
      end
   end
   assign pwm_o = pwm_ff;

   // period of exactly period_i ticks while running
   wrap_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && run_i && period_i != '0 && cnt_ff >= period_i - PW'(1) && $stable(period_i)
      |=> cnt_ff == '0) else $error("pwm counter did not wrap at period");
   full_duty_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && run_i && period_i != '0 && duty_i == DUTY_FULL
      |=> pwm_o) else $error("full duty not high");
   zero_duty_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && duty_i == '0 |=> !pwm_o) else $error("zero duty not low");
endmodule

//--- include/iosm_pkg.sv
// constants and carrier types for the i/o switch matrix with pwm table
// assumes one system clock domain; no timescale in packages
package iosm_pkg;
   localparam int NUM_SRC = 25;
   localparam int NUM_DST = 18;
   localparam int SEL_W = 5;
   localparam logic [SEL_W-1:0] SEL_OFF = 5'h1f; // any code >= NUM_SRC routes nothing
   // source line numbers
   localparam int SRC_TRIG0 = 0;
   localparam int SRC_RX1 = 4;
   localparam int SRC_TX1 = 5;
   localparam int SRC_FLASH0 = 6;
   localparam int SRC_FLASH1 = 7;
   localparam int SRC_PWM_A = 8;
   localparam int SRC_PWM_B = 9;
   localparam int SRC_EXPOSE = 10;
   localparam int SRC_READOUT = 11;
   localparam int SRC_PULSE_A = 12;
   localparam int SRC_PWM_C = 13;
   localparam int SRC_PWM_D = 14;
   localparam int SRC_SEQ_RUN = 15;
   localparam int SRC_DEBOUNCE = 16;
   localparam int SRC_PRESCALE = 17;
   localparam int SRC_PULSE_B = 18;
   localparam int SRC_LOGIC = 19;
   localparam int SRC_FLASH2 = 20;
   localparam int SRC_FLASH3 = 21;
   localparam int SRC_RX2 = 22;
   localparam int SRC_TRIG_FB = 23;
   localparam int SRC_TX2 = 24;
   // destination line numbers
   localparam int DST_OUT0 = 0;
   localparam int DST_SER_TX = 4;
   localparam int DST_PORT1_RX = 5;
   localparam int DST_CAM_TRIG = 6;
   localparam int DST_SEQ_START = 7;
   localparam int DST_DEBOUNCE = 8;
   localparam int DST_PRESCALE = 9;
   localparam int DST_LOGIC_A = 10;
   localparam int DST_LOGIC_B = 11;
   localparam int DST_SER2_TX = 12;
   localparam int DST_FLASH0 = 13;
   localparam int DST_PORT2_RX = 17;
   // pwm table
   localparam int PWM_CH = 4;
   localparam int SEQ_ENTRIES = 16;
   localparam int PERIOD_W = 32;
   localparam int DUTY_W = 7;
   localparam logic [DUTY_W-1:0] DUTY_FULL = 7'h64; // 100 percent
   localparam int TICK_NS = 15; // system tick per period count
   // wishbone register map (word aligned byte addresses)
   localparam logic [7:0] ADDR_ROUTE_BASE = 8'h00; // 18 words, one per line
   localparam logic [7:0] ADDR_ENTRY = 8'h48;
   localparam logic [7:0] ADDR_PERIOD = 8'h4c;
   localparam logic [7:0] ADDR_DUTY = 8'h50;
   localparam logic [7:0] ADDR_STATUS = 8'h54;
   localparam logic [7:0] ADDR_DEST_VAL = 8'h58;
   localparam int ADDR_W = 8;
   // route word field positions
   localparam int RT_INV_BIT = 8;
   localparam int RT_FORCE_BIT = 9;
   localparam int DUTY_LANE_W = 8;

   typedef struct packed {
      logic force_hi;
      logic invert;
      logic [SEL_W-1:0] sel;
   } iosm_route_t;

   localparam iosm_route_t ROUTE_RST = '{force_hi: 1'b0, invert: 1'b0, sel: SEL_OFF};

   typedef struct packed {
      logic [3:0] ext_trig;
      logic [3:0] flash_out;
      logic [3:0] pwm_chan;
      logic pulse_a;
      logic pulse_b;
      logic seq_running;
      logic debounce_out;
      logic prescale_out;
      logic logic_out;
      logic expose_active;
      logic readout_active;
      logic trig_feedback;
      logic ser_rx;
      logic ser2_rx;
      logic port1_serial_tx;
      logic port2_serial_tx;
   } iosm_src_t;
endpackage

//--- tb/iosm_partner_model.sv
`timescale 1ns/1ps
// behavioural stand-in for the camera-side modules and trigger wiring
// assumes the bench sets one pattern bit per source line number
module iosm_partner_model (
   // clock and source pattern
   input wire logic clk_i,
   input wire logic [24:0] pat_i,
   // pins and internal module outputs
   output logic [3:0] ext_trig_o,
   output logic ser_rx_o,
   output logic ser2_rx_o,
   output logic [3:0] flash_out_o,
   output logic pulse_a_o,
   output logic pulse_b_o,
   output logic seq_running_o,
   output logic debounce_out_o,
   output logic prescale_out_o,
   output logic logic_out_o,
   output logic expose_active_o,
   output logic readout_active_o,
   output logic trig_feedback_o,
   output logic port1_serial_tx_o,
   output logic port2_serial_tx_o
);
   // module outputs are registered, as the real modules drive them from flops
   always_ff @(posedge clk_i) begin
      ext_trig_o <= pat_i[3:0];
      ser_rx_o <= pat_i[4];
      port1_serial_tx_o <= pat_i[5];
      flash_out_o <= {pat_i[21], pat_i[20], pat_i[7], pat_i[6]};
      expose_active_o <= pat_i[10];
      readout_active_o <= pat_i[11];
      pulse_a_o <= pat_i[12];
      seq_running_o <= pat_i[15];
      debounce_out_o <= pat_i[16];
      prescale_out_o <= pat_i[17];
      pulse_b_o <= pat_i[18];
      logic_out_o <= pat_i[19];
      ser2_rx_o <= pat_i[22];
      trig_feedback_o <= pat_i[23];
      port2_serial_tx_o <= pat_i[24];
   end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the switch matrix over wishbone
// assumes partner model drives every source except the pwm lines
module tb_top;
   import iosm_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, debug = 1'b0, seq_act = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat;
   logic [24:0] pat = 25'h0;
   logic [31:0] dat_o;
   logic ack, tx, tx_oe, p1rx, cam, seqs, deb, pre, la, lb, s2tx, p2rx;
   logic [3:0] od, oe, fgs, pwm, trig, flash;
   logic srx, s2rx, pa, pb, run, dbo, pso, lgo, exa, rda, tfb, p1tx, p2tx;
   int error_cnt = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [17:0] dst;
   // line levels by number; open-drain lines read back as not-pulled-low
   assign dst = {p2rx, fgs, s2tx, lb, la, pre, deb, seqs, cam, p1rx, tx, ~oe};

   always #4 clk_i = ~clk_i;

   iosm_partner_model iosm_partner_model_i (.clk_i(clk_i), .pat_i(pat),
      .ext_trig_o(trig), .ser_rx_o(srx), .ser2_rx_o(s2rx), .flash_out_o(flash),
      .pulse_a_o(pa), .pulse_b_o(pb), .seq_running_o(run), .debounce_out_o(dbo),
      .prescale_out_o(pso), .logic_out_o(lgo), .expose_active_o(exa),
      .readout_active_o(rda), .trig_feedback_o(tfb), .port1_serial_tx_o(p1tx),
      .port2_serial_tx_o(p2tx));

   iosm_matrix iosm_matrix_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .ext_trig_i(trig), .ser_rx_i(srx), .ser2_rx_i(s2rx), .debug_i(debug),
      .flash_out_i(flash), .pulse_a_i(pa), .pulse_b_i(pb), .seq_running_i(run),
      .seq_active_entry_i(seq_act), .seq_entry_index_i(4'h1), .debounce_out_i(dbo),
      .prescale_out_i(pso), .logic_out_i(lgo), .expose_active_i(exa),
      .readout_active_i(rda), .trig_feedback_i(tfb), .port1_serial_tx_i(p1tx),
      .port2_serial_tx_i(p2tx), .od_out_o(od), .od_oe_o(oe), .ser_tx_o(tx),
      .ser_tx_oe_o(tx_oe), .port1_serial_rx_o(p1rx), .cam_trig_o(cam),
      .seq_hw_start_o(seqs), .debounce_in_o(deb), .prescale_in_o(pre),
      .logic_a_o(la), .logic_b_o(lb), .ser2_tx_o(s2tx),
      .flash_gen_hw_start_o(fgs), .port2_serial_rx_o(p2rx), .seq_pwm_chan_o(pwm));

   task automatic check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // one classic cycle; held until ack is sampled, then released
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic settle();
      repeat (6) @(posedge clk_i);
   endtask

   // reset value of route 0 and of the lines, unmapped read
   task automatic t_reset();
      wb(1'b0, ADDR_ROUTE_BASE, 32'h0);
      check("route0", rdat & 32'h3ff, 32'h1f);
      check("lines", dst, 32'h0);
      wb(1'b0, 8'hfc, 32'h0);
      check("unmapped", rdat, 32'h0);
   endtask

   // each non-pwm source onto the next destination in turn, so every line is hit
   task automatic t_sweep();
      int d;
      d = 0;
      for (int s = 0; s < NUM_SRC; s++) begin
         if (s == SRC_PWM_A || s == SRC_PWM_B || s == SRC_PWM_C || s == SRC_PWM_D)
            continue;
         wb(1'b1, ADDR_ROUTE_BASE + 8'(4 * d), 32'(s));
         pat <= 25'h1 << s;
         settle();
         check("line high", dst, 32'h1 << d);
         wb(1'b0, ADDR_DEST_VAL, 32'h0);
         check("dest reg", rdat & 32'h3ffff, 32'h1 << d);
         pat <= 25'h0;
         settle();
         check("line low", dst, 32'h0);
         d = (d + 1) % NUM_DST;
      end
   endtask

   // off, inverter and force-high on the camera trigger line
   task automatic t_options();
      logic [31:0] cfg [4] = '{32'h01f, 32'h11f, 32'h21f, 32'h31f};
      logic exp_lvl [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, ADDR_ROUTE_BASE + 8'(4 * DST_CAM_TRIG), cfg[i]);
         settle();
         check("cam trig", 32'(cam), 32'(exp_lvl[i]));
      end
      wb(1'b1, ADDR_ROUTE_BASE + 8'(4 * DST_CAM_TRIG), 32'(SRC_TRIG0) | 32'h100);
      pat <= 25'h1;
      settle();
      check("cam inv", 32'(cam), 32'h0);
      // force high on an open-drain line; oe high means pulled low
      wb(1'b1, ADDR_ROUTE_BASE + 8'(4 * DST_OUT0), 32'h21f);
      settle();
      check("od force", 32'(oe[0]), 32'h0);
      wb(1'b1, ADDR_ROUTE_BASE + 8'(4 * DST_OUT0), 32'h31f);
      settle();
      check("od force inv", 32'(oe[0]), 32'h1);
      // flash generator 2 onto flash start 0
      wb(1'b1, ADDR_ROUTE_BASE + 8'(4 * DST_FLASH0), 32'(SRC_FLASH2));
      pat <= 25'h1 << SRC_FLASH2;
      settle();
      check("flash start", 32'(fgs[0]), 32'h1);
      pat <= 25'h0;
   endtask

   // serial tx pin only enabled while debug is low
   task automatic t_debug();
      settle();
      check("tx oe", 32'(tx_oe), 32'h1);
      debug <= 1'b1;
      settle();
      check("tx oe dbg", 32'(tx_oe), 32'h0);
      debug <= 1'b0;
   endtask

   // high ticks per 100 cycles for period 10 and four duties
   task automatic t_pwm();
      int hi [4] = '{0, 0, 0, 0};
      int expv [4] = '{50, 0, 20, 100};
      wb(1'b1, ADDR_ENTRY, 32'h0);
      wb(1'b1, ADDR_PERIOD, 32'd10);
      wb(1'b1, ADDR_DUTY, 32'h64190032);
      wb(1'b0, ADDR_PERIOD, 32'h0);
      check("period", rdat, 32'd10);
      pat <= 25'h1 << SRC_SEQ_RUN;
      repeat (20) @(posedge clk_i);
      repeat (100) begin
         @(posedge clk_i);
         for (int c = 0; c < PWM_CH; c++) hi[c] += (pwm[c] === 1'b1);
      end
      for (int c = 0; c < PWM_CH; c++) check("pwm high", hi[c], expv[c]);
      // channel d at full duty routed onto a line
      wb(1'b1, ADDR_ROUTE_BASE + 8'(4 * DST_LOGIC_A), 32'(SRC_PWM_D));
      settle();
      check("pwm d route", 32'(la), 32'h1);
      pat <= 25'h0;
      // sequencer-chosen entry shows in status while active
      seq_act <= 1'b1;
      wb(1'b0, ADDR_STATUS, 32'h0);
      check("status", rdat & 32'h1e1, 32'h20);
      seq_act <= 1'b0;
   endtask

   // cut a hang short
   always @(posedge clk_i) begin
      cycles++;
      if (cycles > 20000) begin
         error_cnt++;
         wrap_up();
      end
   end

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      settle();
      check("oe reset", 32'(oe), 32'hf);
      check("od level", 32'(od), 32'h0);
      t_reset();
      t_sweep();
      t_options();
      t_debug();
      t_pwm();
      wrap_up();
   end
endmodule
